// *** hdl/ebpp_pkg.sv ***
// Constants, register map and reset values of the external bus port pair.
// Assumes an APB slave with 32-bit data and word-aligned registers.
// How it works
// - High address port has six I/O pins.
// - Address/data port has sixteen I/O pins.
// - Direction set per bit in both ports.
// - High pins output address bits sixteen upward.
// - Sixteen pins carry multiplexed address/data bus.
// - Output pin level follows its latch bit.
// - Latch readable and writable as halfword.
// - Upper and lower latch bytes separately addressable.
// - Every pin has software switchable pull-up.
// - Byte views accept byte access; bit access goes through the bit operation register.
// - Address/data directions reset to all inputs.
package ebpp_pkg;
  localparam int EBPP_HI_W = 6;
  localparam int EBPP_AD_W = 16;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] EBPP_OFF_AD_LATCH = 12'h000;
  localparam logic [11:0] EBPP_OFF_AD_LATCH_LO = 12'h004;
  localparam logic [11:0] EBPP_OFF_AD_LATCH_HI = 12'h008;
  localparam logic [11:0] EBPP_OFF_AD_DIR = 12'h00C;
  localparam logic [11:0] EBPP_OFF_AD_FSEL = 12'h010;
  localparam logic [11:0] EBPP_OFF_AD_PULL = 12'h014;
  localparam logic [11:0] EBPP_OFF_AD_PIN = 12'h018;
  localparam logic [11:0] EBPP_OFF_HI_LATCH = 12'h020;
  localparam logic [11:0] EBPP_OFF_HI_DIR = 12'h024;
  localparam logic [11:0] EBPP_OFF_HI_FSEL = 12'h028;
  localparam logic [11:0] EBPP_OFF_HI_PULL = 12'h02C;
  localparam logic [11:0] EBPP_OFF_HI_PIN = 12'h030;
  localparam logic [11:0] EBPP_OFF_AD_BITOP = 12'h034;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] EBPP_RST_AD_LATCH = 16'h0000;
  localparam logic [15:0] EBPP_RST_AD_DIR = 16'hFFFF;
  localparam logic [15:0] EBPP_RST_AD_FSEL = 16'h0000;
  localparam logic [15:0] EBPP_RST_AD_PULL = 16'h0000;
  localparam logic [5:0] EBPP_RST_HI_LATCH = 6'h00;
  localparam logic [5:0] EBPP_RST_HI_DIR = 6'h3F;
  localparam logic [5:0] EBPP_RST_HI_FSEL = 6'h00;
  localparam logic [5:0] EBPP_RST_HI_PULL = 6'h00;
  // Bit operation register layout: [3:0] bit index, [4] target, [6:5] op.
  localparam int EBPP_BIT_IDX_LSB = 0;
  localparam int EBPP_BIT_TGT_POS = 4;
  localparam int EBPP_BIT_OP_LSB = 5;
  localparam logic [1:0] EBPP_OP_CLR = 2'h0;
  localparam logic [1:0] EBPP_OP_SET = 2'h1;
  localparam logic [1:0] EBPP_OP_NOT = 2'h2;
endpackage

// *** hdl/ebpp_pin_if.sv ***
// Pin bundle between the port core and its pad cell module.
// Assumes one clock domain; all signals are plain levels.
`timescale 1ns/1ps
`default_nettype none
interface ebpp_pin_if #(parameter int W = 16);
  logic [W-1:0] latch;
  logic [W-1:0] dir_in;
  logic [W-1:0] fsel;
  logic [W-1:0] pull;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_oe_n;
  logic [W-1:0] pin_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe_n;
  logic [W-1:0] pull_en;
  logic [W-1:0] level;
  modport core (output latch, dir_in, fsel, pull, alt_out, alt_oe_n, pin_in,
    input pin_out, pin_oe_n, pull_en, level);
  modport pad (input latch, dir_in, fsel, pull, alt_out, alt_oe_n, pin_in,
    output pin_out, pin_oe_n, pull_en, level);
endinterface
`default_nettype wire

// *** hdl/ebpp_pad_mux.sv ***
// Per-pin output mux between port latch and bus controller.
// Assumes the pad resolves the wire from out, oe_n and pull enable.
`timescale 1ns/1ps
`default_nettype none
module ebpp_pad_mux #(parameter int W = 16)
(
  ebpp_pin_if.pad p
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_pin
      // Alternate function overrides latch and direction.
      assign p.pin_out[i] = p.fsel[i] ? p.alt_out[i] : p.latch[i];
      assign p.pin_oe_n[i] = p.fsel[i] ? p.alt_oe_n[i] : p.dir_in[i];
      // Pull-up is only useful while the pin is not driven.
      assign p.pull_en[i] = p.pull[i] & p.pin_oe_n[i];
      assign p.level[i] = p.pin_in[i];
    end
  endgenerate
endmodule
`default_nettype wire

// *** hdl/ebpp_top.sv ***
// Top of the external bus port pair: APB registers and pin control.
// Assumes APB3 master on pclk; pads resolve pins from out and oe_n.
`timescale 1ns/1ps
`default_nettype none
module ebpp_top
  import ebpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] ext_addr_hi,
  input wire logic [15:0] muxed_bus_out,
  input wire logic muxed_bus_oe_n,
  output logic [15:0] muxed_bus_in,
  input wire logic [5:0] hi_pin_in,
  output logic [5:0] hi_pin_out,
  output logic [5:0] hi_pin_oe_n,
  output logic [5:0] hi_pin_pull_en,
  input wire logic [15:0] ad_pin_in,
  output logic [15:0] ad_pin_out,
  output logic [15:0] ad_pin_oe_n,
  output logic [15:0] ad_pin_pull_en
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] addr_data_port_latch_r;
  logic [15:0] addr_data_direction_reg_r;
  logic [15:0] addr_data_function_select_reg_r;
  logic [15:0] ad_pullup_select_r;
  logic [5:0] high_addr_port_latch_r;
  logic [5:0] high_addr_direction_reg_r;
  logic [5:0] high_addr_function_select_reg_r;
  logic [5:0] high_addr_pullup_select_r;
  logic [31:0] prdata_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [15:0] ad_level;
  logic [5:0] hi_level;
  logic [15:0] bit_mask;
  logic [1:0] bit_op;
  logic bit_tgt;

  function automatic logic [15:0] ebpp_bitop(input logic [15:0] v, input logic [15:0] m,
    input logic [1:0] op);
    logic [15:0] r;
    r = v;
    unique case (op)
      EBPP_OP_CLR: r = v & ~m;
      EBPP_OP_SET: r = v | m;
      EBPP_OP_NOT: r = v ^ m;
      default: r = v;
    endcase
    return r;
  endfunction

  function automatic logic ebpp_mapped(input logic [11:0] a);
    return a == EBPP_OFF_AD_LATCH || a == EBPP_OFF_AD_LATCH_LO || a == EBPP_OFF_AD_LATCH_HI ||
      a == EBPP_OFF_AD_DIR || a == EBPP_OFF_AD_FSEL || a == EBPP_OFF_AD_PULL ||
      a == EBPP_OFF_AD_PIN || a == EBPP_OFF_HI_LATCH || a == EBPP_OFF_HI_DIR ||
      a == EBPP_OFF_HI_FSEL || a == EBPP_OFF_HI_PULL || a == EBPP_OFF_HI_PIN ||
      a == EBPP_OFF_AD_BITOP;
  endfunction

  assign addr_ok = ebpp_mapped(paddr);
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;
  assign bit_mask = 16'h0001 << pwdata[EBPP_BIT_IDX_LSB +: 4];
  assign bit_op = pwdata[EBPP_BIT_OP_LSB +: 2];
  assign bit_tgt = pwdata[EBPP_BIT_TGT_POS];
  assign prdata = prdata_r;

  // ****************************************************************
  // Address/data latch with halfword, byte and bit views
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_data_port_latch_r <= EBPP_RST_AD_LATCH;
    else if (wr_en && paddr == EBPP_OFF_AD_LATCH)
      addr_data_port_latch_r <= pwdata[15:0];
    else if (wr_en && paddr == EBPP_OFF_AD_LATCH_LO)
      addr_data_port_latch_r[7:0] <= pwdata[7:0];
    else if (wr_en && paddr == EBPP_OFF_AD_LATCH_HI)
      addr_data_port_latch_r[15:8] <= pwdata[7:0];
    else if (wr_en && paddr == EBPP_OFF_AD_BITOP && !bit_tgt)
      addr_data_port_latch_r <= ebpp_bitop(addr_data_port_latch_r, bit_mask, bit_op);
  end

  // Direction register; ones mean input so all pins float after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_data_direction_reg_r <= EBPP_RST_AD_DIR;
    else if (wr_en && paddr == EBPP_OFF_AD_DIR)
      addr_data_direction_reg_r <= pwdata[15:0];
    else if (wr_en && paddr == EBPP_OFF_AD_BITOP && bit_tgt)
      addr_data_direction_reg_r <= ebpp_bitop(addr_data_direction_reg_r, bit_mask, bit_op);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_data_function_select_reg_r <= EBPP_RST_AD_FSEL;
      ad_pullup_select_r <= EBPP_RST_AD_PULL;
    end
    else
    begin
      if (wr_en && paddr == EBPP_OFF_AD_FSEL)
        addr_data_function_select_reg_r <= pwdata[15:0];
      if (wr_en && paddr == EBPP_OFF_AD_PULL)
        ad_pullup_select_r <= pwdata[15:0];
    end
  end

  // ****************************************************************
  // High address port registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_addr_port_latch_r <= EBPP_RST_HI_LATCH;
      high_addr_direction_reg_r <= EBPP_RST_HI_DIR;
      high_addr_function_select_reg_r <= EBPP_RST_HI_FSEL;
      high_addr_pullup_select_r <= EBPP_RST_HI_PULL;
    end
    else
    begin
      if (wr_en && paddr == EBPP_OFF_HI_LATCH)
        high_addr_port_latch_r <= pwdata[5:0];
      if (wr_en && paddr == EBPP_OFF_HI_DIR)
        high_addr_direction_reg_r <= pwdata[5:0];
      if (wr_en && paddr == EBPP_OFF_HI_FSEL)
        high_addr_function_select_reg_r <= pwdata[5:0];
      if (wr_en && paddr == EBPP_OFF_HI_PULL)
        high_addr_pullup_select_r <= pwdata[5:0];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data is captured in the setup cycle so prdata comes from a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (rd_en)
    begin
      prdata_r <= 32'h0000_0000;
      if (paddr == EBPP_OFF_AD_LATCH)
        prdata_r <= {16'h0000, addr_data_port_latch_r};
      else if (paddr == EBPP_OFF_AD_LATCH_LO)
        prdata_r <= {24'h000000, addr_data_port_latch_r[7:0]};
      else if (paddr == EBPP_OFF_AD_LATCH_HI)
        prdata_r <= {24'h000000, addr_data_port_latch_r[15:8]};
      else if (paddr == EBPP_OFF_AD_DIR)
        prdata_r <= {16'h0000, addr_data_direction_reg_r};
      else if (paddr == EBPP_OFF_AD_FSEL)
        prdata_r <= {16'h0000, addr_data_function_select_reg_r};
      else if (paddr == EBPP_OFF_AD_PULL)
        prdata_r <= {16'h0000, ad_pullup_select_r};
      else if (paddr == EBPP_OFF_AD_PIN)
        prdata_r <= {16'h0000, ad_level};
      else if (paddr == EBPP_OFF_HI_LATCH)
        prdata_r <= {26'h0000000, high_addr_port_latch_r};
      else if (paddr == EBPP_OFF_HI_DIR)
        prdata_r <= {26'h0000000, high_addr_direction_reg_r};
      else if (paddr == EBPP_OFF_HI_FSEL)
        prdata_r <= {26'h0000000, high_addr_function_select_reg_r};
      else if (paddr == EBPP_OFF_HI_PULL)
        prdata_r <= {26'h0000000, high_addr_pullup_select_r};
      else if (paddr == EBPP_OFF_HI_PIN)
        prdata_r <= {26'h0000000, hi_level};
    end
  end

  // ****************************************************************
  // Pin muxes
  // ****************************************************************
  ebpp_pin_if #(.W(EBPP_AD_W)) ad_if();
  ebpp_pin_if #(.W(EBPP_HI_W)) hi_if();

  assign ad_if.latch = addr_data_port_latch_r;
  assign ad_if.dir_in = addr_data_direction_reg_r;
  assign ad_if.fsel = addr_data_function_select_reg_r;
  assign ad_if.pull = ad_pullup_select_r;
  assign ad_if.alt_out = muxed_bus_out;
  assign ad_if.alt_oe_n = {EBPP_AD_W{muxed_bus_oe_n}};
  assign ad_if.pin_in = ad_pin_in;

  assign hi_if.latch = high_addr_port_latch_r;
  assign hi_if.dir_in = high_addr_direction_reg_r;
  assign hi_if.fsel = high_addr_function_select_reg_r;
  assign hi_if.pull = high_addr_pullup_select_r;
  // High address lines are output-only in alternate mode.
  assign hi_if.alt_out = ext_addr_hi;
  assign hi_if.alt_oe_n = 6'h00;
  assign hi_if.pin_in = hi_pin_in;

  ebpp_pad_mux #(.W(EBPP_AD_W)) u_ad_mux (.p(ad_if.pad));
  ebpp_pad_mux #(.W(EBPP_HI_W)) u_hi_mux (.p(hi_if.pad));

  assign ad_level = ad_if.level;
  assign hi_level = hi_if.level;
  assign ad_pin_out = ad_if.pin_out;
  assign ad_pin_oe_n = ad_if.pin_oe_n;
  assign ad_pin_pull_en = ad_if.pull_en;
  assign hi_pin_out = hi_if.pin_out;
  assign hi_pin_oe_n = hi_if.pin_oe_n;
  assign hi_pin_pull_en = hi_if.pull_en;
  // Bus controller sees the raw pins in bit order.
  assign muxed_bus_in = ad_pin_in;
endmodule
`default_nettype wire

// *** testbench/ebpp_assertions.sv ***
// Port-level checks of the port pair top.
// Assumes binding to ebpp_top and full-word APB writes to the select registers.
`timescale 1ns/1ps
`default_nettype none
module ebpp_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] ext_addr_hi,
  input wire logic [15:0] muxed_bus_out,
  input wire logic muxed_bus_oe_n,
  input wire logic [15:0] muxed_bus_in,
  input wire logic [5:0] hi_pin_out,
  input wire logic [5:0] hi_pin_oe_n,
  input wire logic [5:0] hi_pin_pull_en,
  input wire logic [15:0] ad_pin_in,
  input wire logic [15:0] ad_pin_out,
  input wire logic [15:0] ad_pin_oe_n,
  input wire logic [15:0] ad_pin_pull_en
);
  logic [15:0] ad_fsel_r;
  logic [5:0] hi_fsel_r;
  logic [31:0] pw_r;
  logic wr_en;
  logic unmapped;
  assign wr_en = psel && penable && pwrite;
  assign unmapped = (paddr[1:0] != 2'h0) || (paddr > 12'h034) || (paddr == 12'h01C);
  // Select shadows let the pin checks know which pins belong to the bus controller.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ad_fsel_r <= 16'h0000;
    else if (wr_en && paddr == 12'h010)
      ad_fsel_r <= pwdata[15:0];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_fsel_r <= 6'h00;
    else if (wr_en && paddr == 12'h028)
      hi_fsel_r <= pwdata[5:0];
  always_ff @(posedge pclk)
    pw_r <= pwdata;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable |-> pslverr == unmapped) else $error("pslverr wrong");
  a_bus_in_follows: assert property (muxed_bus_in == ad_pin_in) else $error("bus input differs");
  a_reset_inputs: assert property ($rose(presetn) |-> &ad_pin_oe_n && &hi_pin_oe_n) else $error("pin driven");
  a_pull_when_idle: assert property ((ad_pin_pull_en & ~ad_pin_oe_n) == 16'h0000
    && (hi_pin_pull_en & ~hi_pin_oe_n) == 6'h00) else $error("pull on driven pin");
  a_hi_alt_addr: assert property (((hi_pin_out ^ ext_addr_hi) & hi_fsel_r) == 6'h00
    && (hi_pin_oe_n & hi_fsel_r) == 6'h00) else $error("high address wrong");
  a_ad_alt_bus: assert property (((ad_pin_out ^ muxed_bus_out) & ad_fsel_r) == 16'h0000
    && ((ad_pin_oe_n ^ {16{muxed_bus_oe_n}}) & ad_fsel_r) == 16'h0000) else $error("bus pin wrong");
  a_latch_drives: assert property (wr_en && paddr == 12'h000 |=>
    ((ad_pin_out ^ pw_r[15:0]) & ~ad_fsel_r) == 16'h0000) else $error("latch not on pins");
  a_upper_byte: assert property (wr_en && paddr == 12'h008 |=>
    ((ad_pin_out[15:8] ^ pw_r[7:0]) & ~ad_fsel_r[15:8]) == 8'h00) else $error("upper byte wrong");
  c_bit_op: cover property (wr_en && paddr == 12'h034);
  c_alt_mode: cover property (&ad_fsel_r && !muxed_bus_oe_n);
  c_refused: cover property (psel && penable && unmapped);
endmodule
`default_nettype wire

// *** testbench/ebpp_pin_model.sv ***
// Board side of one port: resolves each wire from the pad and outside drivers.
// Assumes the bench never drives a pin that the pad drives.
`timescale 1ns/1ps
`default_nettype none
module ebpp_pin_model #(parameter int W = 16)
(
  input wire logic pclk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] level
);
  logic [W-1:0] flt_r = '0;
  // A floating wire toggles every cycle so a stale value can never pass.
  always_ff @(posedge pclk)
    flt_r <= ~flt_r;
  assign level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & (pull_en | flt_r));
endmodule
`default_nettype wire

// *** testbench/tb_ebpp.sv ***
// Self-checking bench of the port pair top.
// Assumes the pin models close the pad loop; pins are sampled at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_ebpp;
  import ebpp_pkg::*;
  typedef struct {logic [11:0] wa; logic [31:0] w; logic [11:0] ra; logic [31:0] e;} ebpp_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mb_oe_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] eah, hi_in, hi_out, hi_oe_n, hi_pull, hi_ev, hi_ee;
  logic [15:0] mb_out, mb_in, ad_in, ad_out, ad_oe_n, ad_pull, ad_ev, ad_ee;
  int error_cnt = 0;
  int cmp_count = 0;
  ebpp_row_t rows [11] = '{'{12'h000, 32'hFFFFA5C3, 12'h000, 32'hA5C3}, '{12'h004, 32'h5A, 12'h000, 32'hA55A},
    '{12'h008, 32'h12, 12'h000, 32'h125A}, '{12'h000, 32'h1234, 12'h008, 32'h12},
    '{12'h000, 32'h1234, 12'h004, 32'h34}, '{12'h00C, 32'hF00F, 12'h00C, 32'hF00F},
    '{12'h024, 32'h15, 12'h024, 32'h15}, '{12'h020, 32'h2A, 12'h020, 32'h2A}, '{12'h014, 32'hFFFF, 12'h014, 32'hFFFF},
    '{12'h02C, 32'h3F, 12'h02C, 32'h3F}, '{12'h01C, 32'h12345678, 12'h01C, 32'h0}};
  ebpp_top ebpp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_addr_hi(eah),
    .muxed_bus_out(mb_out), .muxed_bus_oe_n(mb_oe_n), .muxed_bus_in(mb_in), .hi_pin_in(hi_in),
    .hi_pin_out(hi_out), .hi_pin_oe_n(hi_oe_n), .hi_pin_pull_en(hi_pull), .ad_pin_in(ad_in),
    .ad_pin_out(ad_out), .ad_pin_oe_n(ad_oe_n), .ad_pin_pull_en(ad_pull));
  ebpp_pin_model #(.W(16)) ebpp_pin_model_inst (.pclk(pclk), .pin_out(ad_out), .pin_oe_n(ad_oe_n),
    .pull_en(ad_pull), .ext_val(ad_ev), .ext_en(ad_ee), .level(ad_in));
  ebpp_pin_model #(.W(6)) ebpp_pin_model_hi_inst (.pclk(pclk), .pin_out(hi_out), .pin_oe_n(hi_oe_n),
    .pull_en(hi_pull), .ext_val(hi_ev), .ext_en(hi_ee), .level(hi_in));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, eah, mb_out} = '0;
    {hi_ev, hi_ee, ad_ev, ad_ee} = '0;
    mb_oe_n = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EBPP_OFF_AD_DIR, 32'h0);
    chk("ad_dir", rd, 32'hFFFF);
    chk("ad_oe_n", {16'h0, ad_oe_n}, 32'hFFFF);
    $display("reset test done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].wa, rows[i].w);
      apb(1'b0, rows[i].ra, 32'h0);
      chk("readback", rd, rows[i].e);
      chk("slverr", {31'h0, err}, {31'h0, rows[i].ra == 12'h01C});
    end
    $display("table test done");
    apb(1'b1, EBPP_OFF_AD_DIR, 32'h0);
    apb(1'b1, EBPP_OFF_AD_LATCH, 32'hC35A);
    apb(1'b0, EBPP_OFF_AD_PIN, 32'h0);
    chk("ad_pin", rd, 32'hC35A);
    apb(1'b0, EBPP_OFF_HI_PIN, 32'h0);
    chk("hi_pin", rd, 32'h3F);
    chk("hi_oe_n", {26'h0, hi_oe_n}, 32'h15);
    apb(1'b1, EBPP_OFF_AD_DIR, 32'hFFFF);
    {ad_ee, ad_ev} <= {16'hFFFF, 16'h3C96};
    apb(1'b0, EBPP_OFF_AD_PIN, 32'h0);
    chk("ad_in", rd, 32'h3C96);
    ad_ee <= 16'h0;
    apb(1'b0, EBPP_OFF_AD_PIN, 32'h0);
    chk("pulled", rd, 32'hFFFF);
    $display("pin test done");
    apb(1'b1, EBPP_OFF_AD_BITOP, 32'h20);
    apb(1'b1, EBPP_OFF_AD_BITOP, 32'h4F);
    apb(1'b1, EBPP_OFF_AD_BITOP, 32'h01);
    apb(1'b1, EBPP_OFF_AD_BITOP, 32'h12);
    apb(1'b1, EBPP_OFF_AD_BITOP, 32'h73);
    apb(1'b0, EBPP_OFF_AD_LATCH, 32'h0);
    chk("bit_latch", rd, 32'h4359);
    apb(1'b0, EBPP_OFF_AD_DIR, 32'h0);
    chk("bit_dir", rd, 32'hFFFB);
    apb(1'b0, EBPP_OFF_AD_BITOP, 32'h0);
    chk("bit_op_read", rd, 32'h0);
    $display("bit test done");
    {eah, mb_out, mb_oe_n} <= {6'h2D, 16'hBEEF, 1'b0};
    apb(1'b1, EBPP_OFF_AD_FSEL, 32'hFFFF);
    apb(1'b1, EBPP_OFF_HI_FSEL, 32'h3F);
    apb(1'b0, EBPP_OFF_AD_FSEL, 32'h0);
    chk("ad_fsel", rd, 32'hFFFF);
    apb(1'b0, EBPP_OFF_HI_FSEL, 32'h0);
    chk("hi_fsel", rd, 32'h3F);
    @(negedge pclk);
    chk("ad_out", {16'h0, ad_out}, 32'hBEEF);
    chk("hi_out", {26'h0, hi_out}, 32'h2D);
    chk("hi_oe_n", {26'h0, hi_oe_n}, 32'h0);
    @(posedge pclk);
    {mb_oe_n, ad_ee, ad_ev} <= {1'b1, 16'hFFFF, 16'h1357};
    @(negedge pclk);
    chk("ad_oe_n", {16'h0, ad_oe_n}, 32'hFFFF);
    chk("mb_in", {16'h0, mb_in}, 32'h1357);
    $display("alternate test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EBPP_OFF_AD_LATCH, 32'h0);
    chk("latch_rst", rd, 32'h0);
    apb(1'b0, EBPP_OFF_HI_DIR, 32'h0);
    chk("hi_dir_rst", rd, 32'h3F);
    $display("second reset test done");
    give_verdict();
  end
endmodule
bind ebpp_top ebpp_assertions ebpp_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ext_addr_hi(ext_addr_hi),
  .muxed_bus_out(muxed_bus_out), .muxed_bus_oe_n(muxed_bus_oe_n), .muxed_bus_in(muxed_bus_in),
  .hi_pin_out(hi_pin_out), .hi_pin_oe_n(hi_pin_oe_n), .hi_pin_pull_en(hi_pin_pull_en), .ad_pin_in(ad_pin_in),
  .ad_pin_out(ad_pin_out), .ad_pin_oe_n(ad_pin_oe_n), .ad_pin_pull_en(ad_pin_pull_en));
`default_nettype wire
